// [pss_pkg.sv]
// Functional notes
// - two sync modes only: address mode and data mode, tied to access events
// - with a sync mode enabled, sync goes low exactly once per access cycle
// - sync falling edge comes slightly ahead of the event of interest
// - sync rising edge marks the moment address or data becomes valid
// - address mode: active from previous latch fall to latch fall in drive phase
// - data mode: source is read, write, program-store or drive phase per access
// - any other sync mode disables the sync output entirely
// - address-latch strobe runs continuously while target power is good, except it is parked high while target reset or resync holds the state counter
// - address-latch strobe stops whenever target power is unsafe
package pss_pkg;

  // ----------------------------------------
  // sync modes and access types
  // ----------------------------------------
  localparam logic [1:0] PSS_MODE_OFF  = 2'h0;
  localparam logic [1:0] PSS_MODE_ADDR = 2'h1;
  localparam logic [1:0] PSS_MODE_DATA = 2'h2;

  localparam logic [1:0] PSS_ACC_READ  = 2'h0;
  localparam logic [1:0] PSS_ACC_WRITE = 2'h1;
  localparam logic [1:0] PSS_ACC_FETCH = 2'h2;
  localparam logic [1:0] PSS_ACC_POD   = 2'h3;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          PSS_CLK_MHZ        = 250;
  localparam int          PSS_RESYNC_US      = 100;
  localparam int          PSS_RESYNC_CYC     = PSS_RESYNC_US * PSS_CLK_MHZ;
  // machine cycle is twelve pod clocks, six state phases of two clocks
  localparam logic [3:0]  PSS_STATES         = 4'hC;
  localparam logic [3:0]  PSS_LATCH_HI_FIRST = 4'h0;
  localparam logic [3:0]  PSS_LATCH_LO_FIRST = 4'h2;
  localparam logic [3:0]  PSS_LATCH2_HI      = 4'h6;
  localparam logic [3:0]  PSS_LATCH2_LO      = 4'h8;
  localparam logic [3:0]  PSS_STROBE_LO      = 4'h4;
  localparam logic [3:0]  PSS_STROBE_HI      = 4'hA;
  localparam logic [3:0]  PSS_LEAD           = 4'h1;

  typedef struct packed {
    logic       valid;
    logic [1:0] kind;
  } pss_access_t;

  typedef struct packed {
    logic addr_latch;
    logic read_n;
    logic write_n;
    logic program_store_strobe_n;
    logic pod_drive_phase;
  } pss_strobes_t;

endpackage

// [pss_sync2.sv]
`timescale 1ns/10ps
module pss_sync2 (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // level
  input  wire logic din,
  output logic      dout
);

  logic meta_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// [pss_sync_gen.sv]
`timescale 1ns/10ps
module pss_sync_gen
  import pss_pkg::*;
#(
  parameter int RESYNC_CYC = PSS_RESYNC_CYC
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // control
  input  wire logic [1:0]   sync_mode,
  input  wire logic         run_request,
  input  wire pss_access_t  access,
  // target pins
  input  wire logic         target_power_ok,
  input  wire logic         target_reset,
  // outputs
  output pss_strobes_t      strobes,
  output logic              sync_n,
  output logic              target_run_mode,
  output logic              restart_at_reset
);

  // ----------------------------------------
  // pin inputs
  // ----------------------------------------
  logic power_ok_s;
  logic reset_s;
  logic reset_prev_q;

  pss_sync2 u_pwr (.ref_clk(ref_clk), .rst_n(rst_n), .din(target_power_ok), .dout(power_ok_s));
  pss_sync2 u_rst (.ref_clk(ref_clk), .rst_n(rst_n), .din(target_reset), .dout(reset_s));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) reset_prev_q <= 1'b0;
    else        reset_prev_q <= reset_s;
  end

  // ----------------------------------------
  // run control and resync
  // ----------------------------------------
  typedef enum logic [2:0] {
    PSS_ST_IDLE   = 3'b001,
    PSS_ST_RUN    = 3'b010,
    PSS_ST_RESYNC = 3'b100
  } pss_run_t;

  pss_run_t     run_q;
  logic [31:0]  resync_cnt_q;
  logic [3:0]   state_q;
  logic         reset_rise;

  assign reset_rise = reset_s && !reset_prev_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q            <= PSS_ST_IDLE;
      resync_cnt_q     <= 32'h0;
      restart_at_reset <= 1'b0;
    end else begin
      restart_at_reset <= 1'b0;
      unique case (run_q)
        PSS_ST_IDLE: begin
          if (run_request) run_q <= PSS_ST_RUN;
        end
        PSS_ST_RUN: begin
          if (reset_rise) begin
            run_q        <= PSS_ST_RESYNC;
            resync_cnt_q <= 32'(RESYNC_CYC - 1);
          end else if (!run_request) begin
            run_q <= PSS_ST_IDLE;
          end
        end
        PSS_ST_RESYNC: begin
          // wait out target reset before counting, a held reset would misalign states
          if (reset_s) begin
            resync_cnt_q <= 32'(RESYNC_CYC - 1);
          end else if (resync_cnt_q == 32'h0) begin
            run_q            <= PSS_ST_RUN;
            restart_at_reset <= 1'b1;
          end else begin
            resync_cnt_q <= resync_cnt_q - 32'h1;
          end
        end
      endcase
    end
  end

  assign target_run_mode = (run_q == PSS_ST_RUN);

  // state counter: held at zero while resyncing so run restarts on a cycle boundary
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)                                       state_q <= 4'h0;
    else if (run_q == PSS_ST_RESYNC || reset_s)       state_q <= 4'h0;
    else if (state_q == PSS_STATES - 4'h1)            state_q <= 4'h0;
    else                                              state_q <= state_q + 4'h1;
  end

  // ----------------------------------------
  // strobes
  // ----------------------------------------
  logic [3:0] ahead;
  logic       latch_d;
  logic       strobe_win;
  assign ahead      = (state_q + PSS_LEAD >= PSS_STATES) ? state_q + PSS_LEAD - PSS_STATES
                                                         : state_q + PSS_LEAD;
  assign latch_d    = (state_q < PSS_LATCH_LO_FIRST) ||
                      (state_q >= PSS_LATCH2_HI && state_q < PSS_LATCH2_LO);
  assign strobe_win = (state_q >= PSS_STROBE_LO) && (state_q < PSS_STROBE_HI);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobes <= '{addr_latch: 1'b0, read_n: 1'b1, write_n: 1'b1,
                   program_store_strobe_n: 1'b1, pod_drive_phase: 1'b0};
    end else begin
      strobes.addr_latch             <= power_ok_s && latch_d;
      strobes.read_n                 <= !(strobe_win && access.valid &&
                                          access.kind == PSS_ACC_READ);
      strobes.write_n                <= !(strobe_win && access.valid &&
                                          access.kind == PSS_ACC_WRITE);
      strobes.program_store_strobe_n <= !(strobe_win && access.valid &&
                                          access.kind == PSS_ACC_FETCH);
      strobes.pod_drive_phase        <= strobe_win && access.valid &&
                                        access.kind == PSS_ACC_POD;
    end
  end

  // ----------------------------------------
  // probe sync
  // ----------------------------------------
  logic sync_addr;
  logic sync_data;
  // address: low from latch fall of previous cycle (state 8) to latch fall of drive (state 2)
  assign sync_addr = (ahead >= PSS_LATCH2_LO) || (ahead < PSS_LATCH_LO_FIRST);
  // data: one clock ahead of the chosen strobe falling, rises one clock before the strobe rises
  assign sync_data = (ahead >= PSS_STROBE_LO) && (state_q < PSS_STROBE_HI - 4'h1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_n <= 1'b1;
    end else begin
      unique case (sync_mode)
        PSS_MODE_ADDR: sync_n <= !(access.valid && sync_addr);
        PSS_MODE_DATA: sync_n <= !(access.valid && sync_data);
        default:       sync_n <= 1'b1;
      endcase
    end
  end

  AST_SYNC_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_mode != PSS_MODE_ADDR && sync_mode != PSS_MODE_DATA) |=> sync_n)
    else $error("sync active in disabled mode");
  AST_LATCH_PWR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !power_ok_s |=> !strobes.addr_latch)
    else $error("latch strobe with bad power");
  AST_LATCH_RUNS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (power_ok_s && !reset_s && state_q == 4'h0) [*3] |=> strobes.addr_latch)
    else $error("latch strobe missing");
  AST_IDLE_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !access.valid |=> sync_n)
    else $error("sync low without access");
  AST_RESYNC_LEAVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (target_run_mode && reset_rise) |=> !target_run_mode)
    else $error("run mode kept on target reset");
  AST_REENTER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restart_at_reset |-> target_run_mode && state_q == 4'h0)
    else $error("rerun not at cycle start");
  AST_DATA_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_mode == PSS_MODE_DATA && access.valid && state_q == PSS_STROBE_HI - 4'h1)
    |=> sync_n)
    else $error("data sync not released on time");
  AST_ADDR_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_mode == PSS_MODE_ADDR && access.valid && state_q == PSS_STROBE_LO)
    |=> sync_n)
    else $error("address sync low outside window");

  // ----------------------------------------
  // latch activity check
  // ----------------------------------------
  // cycles since the last latch rise; cleared while power is bad or the counter is held,
  // since a held counter parks the latch high on purpose
  logic [4:0] latch_gap_q;
  logic       latch_prev_q;
  logic       latch_rise;

  assign latch_rise = strobes.addr_latch && !latch_prev_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_gap_q  <= 5'h0;
      latch_prev_q <= 1'b0;
    end else begin
      latch_prev_q <= strobes.addr_latch;
      if (!power_ok_s || run_q == PSS_ST_RESYNC || reset_s || latch_rise) begin
        latch_gap_q <= 5'h0;
      end else if (latch_gap_q != 5'h1F) begin
        latch_gap_q <= latch_gap_q + 5'h1;
      end
    end
  end

  AST_LATCH_GAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    latch_gap_q < 5'(PSS_STATES))
    else $error("latch strobe stalled with good power");
  AST_DATA_LEAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_mode == PSS_MODE_DATA && access.valid && state_q == PSS_STROBE_LO - 4'h1)
    |=> !sync_n && strobes.read_n && strobes.write_n &&
        strobes.program_store_strobe_n && !strobes.pod_drive_phase)
    else $error("data sync not ahead of strobe");
  AST_ADDR_LEAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_mode == PSS_MODE_ADDR && access.valid && power_ok_s &&
     state_q == PSS_LATCH2_LO - 4'h1)
    |=> !sync_n && strobes.addr_latch)
    else $error("address sync not ahead of latch fall");
  AST_ONE_STROBE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot0({!strobes.read_n, !strobes.write_n,
              !strobes.program_store_strobe_n, strobes.pod_drive_phase}))
    else $error("more than one access strobe active");
  AST_RESTART_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restart_at_reset |=> !restart_at_reset)
    else $error("rerun pulse longer than one cycle");

  COV_ADDR: cover property (@(posedge ref_clk) sync_mode == PSS_MODE_ADDR && !sync_n);
  COV_DATA: cover property (@(posedge ref_clk) sync_mode == PSS_MODE_DATA && !sync_n);
  COV_RESYNC: cover property (@(posedge ref_clk) restart_at_reset);
  COV_BADPWR: cover property (@(posedge ref_clk) !power_ok_s);
  COV_DATA_RISE: cover property (@(posedge ref_clk) sync_mode == PSS_MODE_DATA && $rose(sync_n));

endmodule

// [pss_probe.sv]
`timescale 1ns/10ps
module pss_probe (
  // probe sync from the pod
  input  wire logic  sync_n,
  // node under test
  input  wire logic  node,
  // capture results
  output logic       sample,
  output int unsigned n_samples
);
  initial begin
    sample    = 1'b0;
    n_samples = 0;
  end

  // data counts only on the trailing edge, never while the pulse is low
  always @(posedge sync_n) begin
    sample    <= node;
    n_samples <= n_samples + 1;
  end
endmodule

// [pss_sync_gen_tb.sv]
`timescale 1ns/10ps
module pss_sync_gen_tb;
  import pss_pkg::*;
  localparam int RC = 8;
  logic         ref_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         run_request = 1'b0;
  logic         target_power_ok = 1'b1;
  logic         target_reset = 1'b0;
  logic [1:0]   sync_mode = PSS_MODE_OFF;
  pss_access_t  access = '0;
  pss_strobes_t strobes;
  logic         sync_n, target_run_mode, restart_at_reset, node, sample;
  logic         ps = 1'b1, pl = 1'b0;
  int unsigned  n_samples;
  int           bad_count = 0, n_tests = 0, cyc = 0;
  int           falls, lrises, early, lat_in, lat_pulse;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %0t got %0h expected %0h", $time, a, e); end end

  always #2 ref_clk = ~ref_clk;

  pss_sync_gen #(.RESYNC_CYC(RC)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .sync_mode(sync_mode),
    .run_request(run_request), .access(access), .target_power_ok(target_power_ok),
    .target_reset(target_reset), .strobes(strobes), .sync_n(sync_n),
    .target_run_mode(target_run_mode), .restart_at_reset(restart_at_reset));
  pss_probe probe (.sync_n(sync_n), .node(node), .sample(sample), .n_samples(n_samples));

  // the probed node is the strobe that should be active for the current access
  always_comb begin
    case (access.kind)
      PSS_ACC_READ:  node = ~strobes.read_n;
      PSS_ACC_WRITE: node = ~strobes.write_n;
      PSS_ACC_FETCH: node = ~strobes.program_store_strobe_n;
      default:       node = strobes.pod_drive_phase;
    endcase
  end

  // ----------------------------------------
  // edge monitor and hang guard
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      end_sim();
    end
    if (ps === 1'b1 && sync_n === 1'b0) begin
      falls++;
      early += (node !== 1'b0);
      lat_in = 0;
    end
    if (pl === 1'b1 && strobes.addr_latch === 1'b0 && (sync_n === 1'b0 || ps === 1'b0)) lat_in++;
    if (ps === 1'b0 && sync_n === 1'b1 && lat_in == 0) lat_pulse++;
    if (pl === 1'b0 && strobes.addr_latch === 1'b1) lrises++;
    ps = sync_n;
    pl = strobes.addr_latch;
  end

  task automatic window(input int n);
    @(negedge ref_clk);
    falls = 0; lrises = 0; early = 0; lat_pulse = 0;
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic t_sync(input logic [1:0] m, input logic v, input logic [1:0] k, input int exp);
    int unsigned s0;
    @(posedge ref_clk);
    sync_mode <= m;
    access    <= '{valid: v, kind: k};
    repeat (24) @(posedge ref_clk);
    s0 = n_samples;
    window(48);
    `CHK(falls, exp)
    if (exp == 0) `CHK(sync_n, 1'b1)
    if (m == PSS_MODE_ADDR) `CHK(lat_pulse, 0)
    if (m == PSS_MODE_DATA && v) begin
      `CHK(early, 0)
      `CHK(n_samples - s0, 4)
      `CHK(sample, 1'b1)
    end
    $display("sync test mode %0h kind %0h done", m, k);
  endtask

  task automatic t_power;
    window(48);
    `CHK(lrises, 8)
    @(posedge ref_clk);
    target_power_ok <= 1'b0;
    repeat (4) @(posedge ref_clk);
    window(24);
    `CHK(lrises, 0)
    `CHK(strobes.addr_latch, 1'b0)
    @(posedge ref_clk);
    target_power_ok <= 1'b1;
    repeat (8) @(posedge ref_clk);
    window(24);
    `CHK(lrises, 4)
    $display("power test done");
  endtask

  task automatic t_reset;
    int n;
    @(posedge ref_clk);
    run_request <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 `CHK(target_run_mode, 1'b1)
    @(posedge ref_clk);
    target_reset <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1 `CHK(target_run_mode, 1'b0)
    @(posedge ref_clk);
    target_reset <= 1'b0;
    n = 0;
    while (restart_at_reset !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
      if (restart_at_reset !== 1'b1) `CHK(target_run_mode, 1'b0)
    end
    `CHK(n >= RC && n <= RC + 6, 1'b1)
    repeat (3) @(posedge ref_clk);
    #1 `CHK(target_run_mode, 1'b1)
    $display("target reset test done");
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_sync(PSS_MODE_OFF, 1'b1, PSS_ACC_READ, 0);
    t_sync(2'h3, 1'b1, PSS_ACC_READ, 0);
    t_sync(PSS_MODE_ADDR, 1'b1, PSS_ACC_READ, 4);
    t_sync(PSS_MODE_DATA, 1'b0, PSS_ACC_READ, 0);
    for (int k = 0; k < 4; k++) t_sync(PSS_MODE_DATA, 1'b1, k[1:0], 4);
    t_power();
    t_reset();
    end_sim();
  end
endmodule
